// ---- pkg/bimps_pkg.sv ----
// constants and carrier types for the board interrupt merge and port select block
package bimps_pkg;
	localparam int          NUM_SIDES   = 6;       // two sides on each of three adapters
	localparam int          NUM_SRC     = 7;       // six adapter lines plus the user line
	localparam int          SYNC_W      = 8;       // seven requests and the non-maskable line
	localparam int          SEL_BIT     = 2;       // control bit that picks data or direction
	localparam int          NMI_LINE    = 7;       // position of the non-maskable line
	localparam logic [11:0] ADP_REGION  = 12'h800; // upper address bits of the adapter window
	localparam logic [1:0]  ADP_LAST    = 2'h2;    // highest adapter index in the window
	localparam int          OFS_SIDE    = 1;       // address bit that picks side b
	localparam int          OFS_CTRL    = 0;       // address bit that picks the control register
	localparam logic [15:0] IRQ_VEC_HI  = 16'hCFF8;
	localparam logic [15:0] IRQ_VEC_LO  = 16'hCFF9;
	localparam logic [15:0] NMI_VEC_HI  = 16'hCFFC;
	localparam logic [15:0] NMI_VEC_LO  = 16'hCFFD;
	localparam logic [7:0]  REG_RST     = 8'h00;
	localparam logic [7:0]  SYNC_RST    = 8'hFF;   // idle level of every active-low line

	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] ddr;
		logic [7:0] data;
	} bimps_side_t;

	typedef struct packed {
		logic        fetch;
		logic        nmi;
		logic [15:0] addr;
	} bimps_vec_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_HI   = 2'b01,
		ST_LO   = 2'b10
	} bimps_state_t;
endpackage : bimps_pkg

// ---- src/bimps_sync.sv ----
// three-stage synchroniser for the active-low request and non-maskable pins
`timescale 1ns/1ps
module bimps_sync
	import bimps_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              sys_rst,
	input  wire logic [SYNC_W-1:0] async_in,
	output logic      [SYNC_W-1:0] sync_out
);
	logic [SYNC_W-1:0] st1_r;
	logic [SYNC_W-1:0] st2_r;
	logic [SYNC_W-1:0] st3_r;
	logic [SYNC_W-1:0] out_r;
	logic [SYNC_W-1:0] out_nxt;

	// a bit moves only once stages two and three agree, so one glitchy sample never counts
	always_comb begin
		out_nxt = out_r;
		for (int i = 0; i < SYNC_W; i++) begin
			if (st2_r[i] == st3_r[i]) begin
				out_nxt[i] = st3_r[i];
			end
		end
	end

	// stage chain resets to idle high so no request is seen straight after reset
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			st1_r <= SYNC_RST;
			st2_r <= SYNC_RST;
			st3_r <= SYNC_RST;
			out_r <= SYNC_RST;
		end else begin
			st1_r <= async_in;
			st2_r <= st1_r;
			st3_r <= st2_r;
			out_r <= out_nxt;
		end
	end

	// output comes straight from a flip-flop; costs one cycle of latency
	assign sync_out = out_r;
endmodule : bimps_sync

// ---- src/bimps_top.sv ----
// board glue: adapter register decode, interrupt merge and vector fetch sequencing
// Function
// RQ1 - adapters decode as plain memory locations reached by loads and stores
// RQ2 - control bit 2 steers shared address to data or direction register
// RQ3 - processor writes select bit before touching data or direction register
// RQ4 - seven sources merge onto one maskable request: six adapter, one user
// RQ5 - a pending request is taken only after the current instruction ends
// RQ6 - with mask clear, handler address is fetched from CFF8 then CFF9
// RQ7 - handler polls sources; polling order sets priority, first is highest
// RQ8 - maskable request is level sensitive, active low, held while asserted
// RQ9 - non-maskable line acts on falling edge, after instruction, ignoring mask
// RQ10 - merged request is active-low wired-OR, released only when all release
`timescale 1ns/1ps
module bimps_top
	import bimps_pkg::*;
(
	input  wire logic                       clock,
	input  wire logic                       sys_rst,
	input  wire logic [15:0]                cpu_addr,
	input  wire logic                       cpu_wr,
	input  wire logic                       cpu_rd,
	input  wire logic [7:0]                 cpu_wdata,
	input  wire logic [NUM_SRC-1:0]         irq_src_n,
	input  wire logic                       nmi_n,
	input  wire logic                       instr_done,
	input  wire logic                       irq_mask,
	output logic      [7:0]                 rdata_r,
	output bimps_side_t [NUM_SIDES-1:0]     side_r,
	output logic                            irq_n_r,
	output bimps_vec_t                      vec_r
);
	logic [SYNC_W-1:0]               lines_s;
	logic                            nmi_prev_r;
	logic                            nmi_prev_nxt;
	logic                            nmi_pend_r;
	logic                            nmi_pend_nxt;
	logic                            nmi_fall;
	logic                            irq_n_nxt;
	logic [7:0]                      rdata_nxt;
	bimps_side_t [NUM_SIDES-1:0]     side_nxt;
	bimps_vec_t                      vec_nxt;
	bimps_state_t                    st_r;
	bimps_state_t                    st_nxt;
	logic                            hit;
	logic [2:0]                      sidx;
	logic                            take_nmi;
	logic                            take_irq;

	// address is inside the window and names one of the three adapters
	function automatic logic adp_hit(input logic [15:0] a);
		adp_hit = (a[15:4] == ADP_REGION) && (a[3:2] <= ADP_LAST);
	endfunction : adp_hit

	// side index: two sides per adapter, side b on the side address bit
	function automatic logic [2:0] side_index(input logic [15:0] a);
		side_index = {a[3:2], a[OFS_SIDE]};
	endfunction : side_index

	bimps_sync u_sync (
		.clock    (clock),
		.sys_rst  (sys_rst),
		.async_in ({nmi_n, irq_src_n}),
		.sync_out (lines_s)
	);

	assign hit  = adp_hit(cpu_addr);                            // [RQ1]
	assign sidx = side_index(cpu_addr);

	// register writes and reads: memory decode, select bit chooses data or direction
	always_comb begin
		side_nxt  = side_r;
		rdata_nxt = REG_RST;                                    // unmapped reads return zero
		if (hit && cpu_wr) begin                                // [RQ1]
			if (cpu_addr[OFS_CTRL]) begin
				side_nxt[sidx].ctrl = cpu_wdata;
			end else if (side_r[sidx].ctrl[SEL_BIT]) begin      // [RQ2]
				side_nxt[sidx].data = cpu_wdata;
			end else begin
				side_nxt[sidx].ddr = cpu_wdata;                 // [RQ2]
			end
		end
		if (hit && cpu_rd) begin
			if (cpu_addr[OFS_CTRL]) begin
				rdata_nxt = side_r[sidx].ctrl;
			end else if (side_r[sidx].ctrl[SEL_BIT]) begin      // [RQ2]
				rdata_nxt = side_r[sidx].data;
			end else begin
				rdata_nxt = side_r[sidx].ddr;
			end
		end
	end

	// register bank and read reply; the reply drops back to zero one cycle after a read
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			side_r  <= '0;
			rdata_r <= REG_RST;
		end else begin
			side_r  <= side_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// merged request: any low source pulls the line low, like an open-collector bus
	always_comb begin
		irq_n_nxt = &lines_s[NUM_SRC-1:0];                      // [RQ4] [RQ10] [RQ8]
	end

	// merged line registered so the processor never sees a combinational glitch
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			irq_n_r <= 1'b1;
		end else begin
			irq_n_r <= irq_n_nxt;
		end
	end

	// non-maskable edge latch; a new edge during the take keeps it pending (set wins)
	assign nmi_fall = nmi_prev_r & ~lines_s[NMI_LINE];          // [RQ9]
	always_comb begin
		nmi_prev_nxt = lines_s[NMI_LINE];
		nmi_pend_nxt = nmi_fall | (nmi_pend_r & ~take_nmi);
	end

	// previous level resets to idle high so no false edge follows reset
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			nmi_prev_r <= 1'b1;
			nmi_pend_r <= 1'b0;
		end else begin
			nmi_prev_r <= nmi_prev_nxt;
			nmi_pend_r <= nmi_pend_nxt;
		end
	end

	// takes happen only on an instruction boundary; non-maskable outranks the level request
	assign take_nmi = (st_r == ST_IDLE) && instr_done && nmi_pend_r;              // [RQ5] [RQ9]
	assign take_irq = (st_r == ST_IDLE) && instr_done && !nmi_pend_r
	                  && !irq_n_r && !irq_mask;                                   // [RQ5] [RQ8]

	// vector fetch: high byte location, then low byte location, one cycle each
	always_comb begin
		st_nxt        = st_r;
		vec_nxt       = vec_r;
		vec_nxt.fetch = 1'b0;
		unique case (st_r)
			ST_IDLE: begin
				if (take_nmi) begin
					st_nxt  = ST_HI;
					vec_nxt = '{fetch: 1'b1, nmi: 1'b1, addr: NMI_VEC_HI};
				end else if (take_irq) begin
					st_nxt  = ST_HI;
					vec_nxt = '{fetch: 1'b1, nmi: 1'b0, addr: IRQ_VEC_HI};       // [RQ6]
				end
			end
			ST_HI: begin
				st_nxt        = ST_LO;
				vec_nxt.fetch = 1'b1;
				vec_nxt.addr  = vec_r.nmi ? NMI_VEC_LO : IRQ_VEC_LO;             // [RQ6]
			end
			ST_LO: begin
				st_nxt = ST_IDLE;
			end
			default: begin
				st_nxt = ST_IDLE;
			end
		endcase
	end

	// sequencer state and the fetch address shown to the processor
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			st_r  <= ST_IDLE;
			vec_r <= '0;
		end else begin
			st_r  <= st_nxt;
			vec_r <= vec_nxt;
		end
	end

	// checkers on the design's own state; all run on the one bus clock
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	a_merge_low:   assert property (!(&lines_s[NUM_SRC-1:0]) |=> !irq_n_r) // [RQ4]
		else $error("merged request not asserted by a low source");
	a_merge_rel:   assert property ((&lines_s[NUM_SRC-1:0]) |=> irq_n_r) // [RQ10]
		else $error("merged request held with all sources released");
	a_irq_vector:  assert property (take_irq |=> vec_r.fetch && vec_r.addr == IRQ_VEC_HI
	                              ##1 vec_r.fetch && vec_r.addr == IRQ_VEC_LO) // [RQ6]
		else $error("maskable vector not fetched from its two locations");
	a_wait_instr:  assert property (st_r == ST_IDLE && !instr_done |=> !vec_r.fetch) // [RQ5]
		else $error("vector fetch started inside an instruction");
	a_mask_holds:  assert property (st_r == ST_IDLE && irq_mask && !nmi_pend_r
	                              |=> st_r == ST_IDLE) // [RQ8]
		else $error("masked request was taken");
	a_nmi_edge:    assert property (nmi_fall |=> nmi_pend_r) // [RQ9]
		else $error("falling edge on the non-maskable line lost");
	a_nmi_nomask:  assert property (take_nmi |=> vec_r.nmi && vec_r.addr == NMI_VEC_HI) // [RQ9]
		else $error("non-maskable take did not start its sequence");
	a_sel_data:    assert property (hit && cpu_wr && !cpu_addr[OFS_CTRL]
	                              && side_r[sidx].ctrl[SEL_BIT]
	                              |=> side_r[$past(sidx)].data == $past(cpu_wdata)) // [RQ2]
		else $error("select bit set but data register not written");
	a_sel_ddr:     assert property (hit && cpu_wr && !cpu_addr[OFS_CTRL]
	                              && !side_r[sidx].ctrl[SEL_BIT]
	                              |=> side_r[$past(sidx)].ddr == $past(cpu_wdata)) // [RQ2]
		else $error("select bit clear but direction register not written");
	a_read_map:    assert property (!(hit && cpu_rd) |=> rdata_r == REG_RST) // [RQ1]
		else $error("read data present without a mapped read");
	a_read_ctrl:   assert property (hit && cpu_rd && !cpu_wr && cpu_addr[OFS_CTRL]
	                              |=> rdata_r == side_r[$past(sidx)].ctrl) // [RQ1]
		else $error("control register read returned wrong data");

	// take decisions written from the raw conditions; the non-maskable vector check starts from take_nmi
	a_irq_level:   assert property (st_r == ST_IDLE && instr_done && !nmi_pend_r
	                              && !irq_n_r && !irq_mask
	                              |=> vec_r.fetch && !vec_r.nmi) // [RQ8]
		else $error("unmasked level request not taken at a boundary");
	a_nmi_first:   assert property (st_r == ST_IDLE && instr_done && nmi_pend_r
	                              |=> vec_r.fetch && vec_r.nmi) // [RQ9]
		else $error("non-maskable request lost to the level request");
	a_nmi_vector:  assert property (take_nmi |=> (vec_r.fetch && vec_r.addr == NMI_VEC_HI)
	                              ##1 (vec_r.fetch && vec_r.addr == NMI_VEC_LO)) // [RQ9]
		else $error("non-maskable vector not fetched from its two locations");

	// the low byte fetch is always followed by one quiet cycle before another take
	a_fetch_gap:   assert property (vec_r.fetch
	                              && (vec_r.addr == IRQ_VEC_LO || vec_r.addr == NMI_VEC_LO)
	                              |=> !vec_r.fetch) // [RQ5]
		else $error("new vector fetch started without an idle cycle");
	a_pend_quiet:  assert property (!nmi_pend_r && !nmi_fall |=> !nmi_pend_r) // [RQ9]
		else $error("non-maskable request pending without a falling edge");
endmodule : bimps_top

// ---- bench/bimps_cpu_model.sv ----
// processor core model: marks instruction boundaries and drives the condition-code mask
`timescale 1ns/1ps
module bimps_cpu_model (
	input  wire logic clock,
	input  wire logic sys_rst,
	input  wire logic run,
	input  wire logic mask_in,
	output logic      instr_done,
	output logic      irq_mask
);
	logic [1:0] gap_r;

	// instructions of random length; no boundary at all while halted
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			instr_done <= 1'b0;
			gap_r      <= 2'h0;
		end else if (gap_r == 2'h0) begin
			instr_done <= run;
			gap_r      <= 2'($urandom % 4);
		end else begin
			instr_done <= 1'b0;
			gap_r      <= gap_r - 2'h1;
		end
	end

	// mask passes straight through so a handler can block re-entry at once
	assign irq_mask = mask_in;
endmodule : bimps_cpu_model

// ---- bench/bimps_bench.sv ----
// self-checking bench for the interrupt merge and adapter register select block
`timescale 1ns/1ps
module bimps_bench;
	import bimps_pkg::*;
	logic                       clock, sys_rst, cpu_wr, cpu_rd, nmi_n, run, mask_in;
	logic                       instr_done, irq_mask, irq_n_r, rd_q;
	logic [15:0]                cpu_addr, b;
	logic [7:0]                 cpu_wdata, rdata_r, d, e;
	logic [NUM_SRC-1:0]         irq_src_n;
	bimps_side_t [NUM_SIDES-1:0] side_r;
	bimps_vec_t                 vec_r;
	int                         err_count, samples_checked, cycles;
	logic [7:0]                 rq[$];
	logic [16:0]                vq[$];

	bimps_top i_dut (.clock(clock), .sys_rst(sys_rst), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
		.cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .irq_src_n(irq_src_n), .nmi_n(nmi_n),
		.instr_done(instr_done), .irq_mask(irq_mask), .rdata_r(rdata_r), .side_r(side_r),
		.irq_n_r(irq_n_r), .vec_r(vec_r));
	bimps_cpu_model i_cpu (.clock(clock), .sys_rst(sys_rst), .run(run), .mask_in(mask_in),
		.instr_done(instr_done), .irq_mask(irq_mask));

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic chk(input logic ok, input string m);
		samples_checked++;
		if (ok !== 1'b1) begin
			err_count++;
			$display("ERROR %0t %s", $time, m);
		end
	endtask : chk

	task test_done;
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : test_done

	// strobes are held for exactly one sampling edge, then dropped
	task wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge clock);
		cpu_wr <= 1'b1; cpu_addr <= a; cpu_wdata <= v;
		@(posedge clock);
		cpu_wr <= 1'b0;
	endtask : wr

	task rd(input logic [15:0] a, input logic [7:0] v);
		@(posedge clock);
		cpu_rd <= 1'b1; cpu_addr <= a;
		rq.push_back(v);
		@(posedge clock);
		cpu_rd <= 1'b0;
	endtask : rd

	task automatic wait_q(input int n);
		int k;
		k = 0;
		while (vq.size() > n && k < 300) begin
			@(posedge clock);
			k++;
		end
		if (k >= 300) chk(1'b0, "vector fetch never came");
	endtask : wait_q

	// read reply is registered at the sampling edge, so the flag matches it
	always @(posedge clock) rd_q <= sys_rst ? 1'b0 : cpu_rd;

	// watcher samples at the falling edge where all outputs have settled
	always @(negedge clock) begin
		if (!sys_rst) begin
			if (rd_q && rq.size() == 0) chk(1'b0, "read reply without a read");
			else if (rd_q) chk(rdata_r === rq.pop_front(), "read data");
			else if (rdata_r !== 8'h00) chk(1'b0, "read data outside a read");
			// an unknown fetch flag counts as a fetch so it cannot slip through
			if (vec_r.fetch !== 1'b0 && vq.size() == 0)
				chk(1'b0, "unexpected vector fetch");
			else if (vec_r.fetch !== 1'b0)
				chk({vec_r.nmi, vec_r.addr} === vq.pop_front(), "vector");
		end
	end

	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			$display("ERROR %0t run did not finish", $time);
			test_done();
		end
	end

	initial begin
		sys_rst = 1'b1; cpu_wr = 1'b0; cpu_rd = 1'b0; cpu_addr = 16'h0000; cpu_wdata = 8'h00;
		irq_src_n = 7'h7F; nmi_n = 1'b1; run = 1'b0; mask_in = 1'b1;
		void'($urandom(87037));
		repeat (20) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		chk(irq_n_r === 1'b1 && vec_r === '0 && side_r === '0, "reset values");
		// every side: select direction, fill it, select data, fill it, read both back
		for (int s = 0; s < NUM_SIDES; s++) begin
			b = 16'h8000 + 16'(4 * (s / 2) + 2 * (s % 2));
			d = 8'($urandom);
			e = 8'($urandom);
			wr(b + 16'h1, 8'h00);
			wr(b, d);
			rd(b, d);
			wr(b + 16'h1, 8'h04);
			wr(b, e);
			rd(b, e);
			rd(b + 16'h1, 8'h04);
			chk(side_r[s].ddr === d && side_r[s].data === e, "side contents");
		end
		wr(16'h800D, 8'hFF);
		rd(16'h800D, 8'h00);
		rd(16'h9001, 8'h00);
		// each of the seven sources alone: halted, masked, then taken
		for (int i = 0; i < NUM_SRC; i++) begin
			@(posedge clock);
			irq_src_n[i] <= 1'b0; mask_in <= 1'b0;
			repeat (10) @(posedge clock);
			chk(irq_n_r === 1'b0, "merged request low");
			mask_in <= 1'b1; run <= 1'b1;
			repeat (12) @(posedge clock);
			vq.push_back({1'b0, IRQ_VEC_HI});
			vq.push_back({1'b0, IRQ_VEC_LO});
			mask_in <= 1'b0;
			wait_q(1);
			mask_in <= 1'b1; run <= 1'b0;
			wait_q(0);
			irq_src_n[i] <= 1'b1;
			repeat (6) @(posedge clock);
			chk(irq_n_r === 1'b1, "merged request released");
		end
		// two sources share the line; it stays low until both let go
		irq_src_n <= 7'h3E;
		repeat (8) @(posedge clock);
		irq_src_n <= 7'h3F;
		repeat (8) @(posedge clock);
		chk(irq_n_r === 1'b0, "one source still low");
		irq_src_n <= 7'h7F;
		repeat (8) @(posedge clock);
		chk(irq_n_r === 1'b1, "all sources released");
		// non-maskable edge is taken with the mask set
		vq.push_back({1'b1, NMI_VEC_HI});
		vq.push_back({1'b1, NMI_VEC_LO});
		run <= 1'b1; nmi_n <= 1'b0;
		wait_q(0);
		nmi_n <= 1'b1;
		repeat (8) @(posedge clock);
		// non-maskable outranks a pending level request; the level one follows after
		irq_src_n[0] <= 1'b0;
		mask_in      <= 1'b0;
		run          <= 1'b0;
		nmi_n        <= 1'b0;
		repeat (10) @(posedge clock);
		vq.push_back({1'b1, NMI_VEC_HI});
		vq.push_back({1'b1, NMI_VEC_LO});
		vq.push_back({1'b0, IRQ_VEC_HI});
		vq.push_back({1'b0, IRQ_VEC_LO});
		run <= 1'b1;
		wait_q(1);
		mask_in <= 1'b1;
		run     <= 1'b0;
		wait_q(0);
		irq_src_n[0] <= 1'b1;
		nmi_n        <= 1'b1;
		repeat (8) @(posedge clock);
		// second reset in mid-run: contents clear and the first read sees zero
		sys_rst <= 1'b1;
		repeat (3) @(posedge clock);
		sys_rst <= 1'b0;
		@(negedge clock);
		chk(irq_n_r === 1'b1 && vec_r === '0 && side_r === '0, "values after reset");
		rd(16'h8002, 8'h00);
		repeat (30) @(posedge clock);
		test_done();
	end
endmodule : bimps_bench
